// ---- rtl/ltr_template_alarm_regs.sv ----
// register slice: template select, output disable, alarm status and bank pointer
module ltr_template_alarm_regs
  import ltr_pkg::*;
#(
  parameter bit VARIANT_75 = 1'b0
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // register port
  input  wire ltr_reg_req_s            reg_req,
  output logic [7:0]                   rd_data_r,
  // pins and neighbouring logic
  input  wire logic                    oe_pin,
  input  wire logic [NCH-1:0]          ais_detect,
  input  wire logic [NCH-1:0]          loss_alarm_criteria_select,
  input  wire logic                    clear_on_write_select,
  // channel controls, alarm outputs and bank select
  output ltr_chan_cfg_s [NCH-1:0]      chan_cfg_r,
  output logic [NCH-1:0]               tx_hiz_r,
  output logic [NCH-1:0]               ais_status_r,
  output logic [NCH-1:0]               ais_irq_req_r,
  output ltr_bank_e                    bank_sel_r
);

  // ==========================================================
  // state
  logic [7:0]     bank_r;
  logic [2:0]     ptr_r;
  logic [7:0]     tpl_r   [NCH];
  logic [7:0]     tpl_nxt [NCH];
  logic [NCH-1:0] out_dis_r;
  logic [NCH-1:0] ie_r;
  logic [NCH-1:0] is_r;
  logic [NCH-1:0] is_nxt;
  logic           oe_s1_r;
  logic           oe_s2_r;
  logic           oe_s3_r;
  logic           oe_level_r;
  ltr_chan_cfg_s [NCH-1:0] cfg_w;

  // ==========================================================
  // address decode
  wire logic pri_w    = (bank_decode(bank_r) == BANK_PRI);
  wire logic wr_pri_w = reg_req.wr & pri_w;
  wire logic rd_pri_w = reg_req.rd & pri_w;
  wire logic wr_bank  = reg_req.wr & (reg_req.addr == OFF_BANK);
  wire logic wr_ptr   = wr_pri_w & (reg_req.addr == OFF_POINTER);
  wire logic wr_tpl   = wr_pri_w & (reg_req.addr == OFF_TEMPLATE);
  wire logic wr_dis   = wr_pri_w & (reg_req.addr == OFF_OUT_DIS);
  wire logic wr_ie    = wr_pri_w & (reg_req.addr == OFF_AIS_IE);
  wire logic wr_is    = wr_pri_w & (reg_req.addr == OFF_AIS_IS);
  wire logic rd_is    = rd_pri_w & (reg_req.addr == OFF_AIS_IS);

  wire logic [2:0] wr_code  = reg_req.wdata[2:0];
  wire logic [2:0] cur_code = tpl_r[ptr_r][2:0];
  wire logic       code_ok  = tpl_valid(wr_code);

  // ==========================================================
  // per-channel template storage and decode
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      wire logic sel_w = (ptr_r == 3'(gi));
      assign tpl_nxt[gi] = (wr_tpl && sel_w) ?
                           {reg_req.wdata[7:6], 2'b00, reg_req.wdata[3],
                            code_ok ? wr_code : tpl_r[gi][2:0]} : tpl_r[gi];
      ltr_chan_decode #(
        .VARIANT_75 (VARIANT_75)
      ) u_dec (
        .tpl_byte (tpl_r[gi]),
        .crit_bit (loss_alarm_criteria_select[gi]),
        .cfg      (cfg_w[gi])
      );
      // decode of each channel reaches its outputs one cycle later
      property p_cfg_follow;
        @(posedge clk) disable iff (rst)
        1 |=> (chan_cfg_r[gi].rx_match_off == $past(tpl_r[gi][TPL_RX_OFF_BIT]))
              && (chan_cfg_r[gi].tx_term_off == $past(tpl_r[gi][TPL_TX_OFF_BIT]));
      endproperty
      a_cfg_follow: assert property (p_cfg_follow) else $error("rx/tx impedance off bits wrong");
      property p_ohm;
        @(posedge clk) disable iff (rst)
        !$past(rst) && ($past(tpl_r[gi][2:0]) == TPL_E1) && !$past(tpl_r[gi][TPL_IMP_BIT])
          |-> chan_cfg_r[gi].ohm == (VARIANT_75 ? OHM_75 : OHM_120);
      endproperty
      a_ohm: assert property (p_ohm) else $error("E1 default impedance wrong");
      property p_crit;
        @(posedge clk) disable iff (rst)
        ($past(tpl_r[gi][2:0]) != TPL_E1) |-> (chan_cfg_r[gi].crit == CRIT_T1231)
                                               && chan_cfg_r[gi].t1_mode;
      endproperty
      a_crit: assert property (p_crit) else $error("T1 criteria not applied");
    end
  endgenerate

  // ==========================================================
  // alarm status and interrupt latch
  wire logic [NCH-1:0] ais_change = ais_detect ^ ais_status_r;
  wire logic [NCH-1:0] is_clr     = clear_on_write_select ?
                                    (wr_is ? reg_req.wdata : '0) :
                                    (rd_is ? is_r : '0);
  assign is_nxt = (is_r & ~is_clr) | ais_change;

  // ==========================================================
  // read path
  wire logic [7:0] rd_mux =
    (reg_req.addr == OFF_BANK)            ? bank_r :
    !pri_w                                ? 8'h00 :
    (reg_req.addr == OFF_POINTER)         ? {5'h00, ptr_r} :
    (reg_req.addr == OFF_TEMPLATE)        ? tpl_r[ptr_r] :
    (reg_req.addr == OFF_OUT_DIS)         ? out_dis_r :
    (reg_req.addr == OFF_AIS)             ? ais_status_r :
    (reg_req.addr == OFF_AIS_IE)          ? ie_r :
    (reg_req.addr == OFF_AIS_IS)          ? is_r : 8'h00;

  // ==========================================================
  // output enable pin sampler
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_s1_r    <= 1'b0;
      oe_s2_r    <= 1'b0;
      oe_s3_r    <= 1'b0;
      oe_level_r <= 1'b0;
    end else begin
      oe_s1_r <= oe_pin;
      oe_s2_r <= oe_s1_r;
      oe_s3_r <= oe_s2_r;
      if (oe_s2_r == oe_s3_r) begin
        oe_level_r <= oe_s3_r;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_r    <= RST_BYTE;
      ptr_r     <= RST_POINTER;
      out_dis_r <= RST_BYTE;
      ie_r      <= RST_BYTE;
      is_r      <= RST_BYTE;
      for (int i = 0; i < NCH; i++) begin
        tpl_r[i] <= RST_BYTE;
      end
    end else begin
      if (wr_bank) begin
        bank_r <= reg_req.wdata;
      end
      if (wr_ptr) begin
        ptr_r <= wr_code;
      end
      if (wr_dis) begin
        out_dis_r <= reg_req.wdata;
      end
      if (wr_ie) begin
        ie_r <= reg_req.wdata;
      end
      is_r <= is_nxt;
      for (int i = 0; i < NCH; i++) begin
        tpl_r[i] <= tpl_nxt[i];
      end
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_r     <= 8'h00;
      chan_cfg_r    <= '0;
      tx_hiz_r      <= '1;
      ais_status_r  <= '0;
      ais_irq_req_r <= '0;
      bank_sel_r    <= BANK_PRI;
    end else begin
      if (reg_req.rd) begin
        rd_data_r <= rd_mux;
      end
      chan_cfg_r    <= cfg_w;
      tx_hiz_r      <= oe_level_r ? out_dis_r : '1;
      ais_status_r  <= ais_detect;
      ais_irq_req_r <= is_r & ie_r;
      bank_sel_r    <= bank_decode(bank_r);
    end
  end

  // ==========================================================
  // checks
  sequence s_ptr_write;
    wr_ptr;
  endsequence

  sequence s_tpl_write;
    wr_tpl;
  endsequence

  property p_ptr_sel;
    @(posedge clk) disable iff (rst)
    s_ptr_write |=> (ptr_r == $past(reg_req.wdata[2:0]));
  endproperty
  a_ptr_sel: assert property (p_ptr_sel) else $error("pointer not taken");

  property p_tpl_route;
    @(posedge clk) disable iff (rst)
    s_tpl_write |=> (tpl_r[$past(ptr_r)][7:6] == $past(reg_req.wdata[7:6]));
  endproperty
  a_tpl_route: assert property (p_tpl_route) else $error("template write went astray");

  property p_tpl_keep;
    @(posedge clk) disable iff (rst)
    s_tpl_write ##0 !code_ok |=> (tpl_r[$past(ptr_r)][2:0] == $past(cur_code));
  endproperty
  a_tpl_keep: assert property (p_tpl_keep) else $error("reserved template code stored");

  property p_tpl_code;
    @(posedge clk) disable iff (rst)
    s_tpl_write ##0 code_ok ##1 1'b1 ##1 1'b1
      |-> chan_cfg_r[$past(ptr_r, 2)].cable_tpl == $past(wr_code, 2);
  endproperty
  a_tpl_code: assert property (p_tpl_code) else $error("line mode not decoded");

  property p_hiz_dis;
    @(posedge clk) disable iff (rst)
    oe_level_r |=> (tx_hiz_r == $past(out_dis_r));
  endproperty
  a_hiz_dis: assert property (p_hiz_dis) else $error("disable bits not applied");

  property p_oe_override;
    @(posedge clk) disable iff (rst)
    (!oe_s2_r && !oe_s3_r) [*2] |=> ##1 (tx_hiz_r == '1);
  endproperty
  a_oe_override: assert property (p_oe_override) else $error("pin low did not override");

  property p_ais_follow;
    @(posedge clk) disable iff (rst)
    1 |=> (ais_status_r == $past(ais_detect));
  endproperty
  a_ais_follow: assert property (p_ais_follow) else $error("alarm status stale");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
    1 |=> ((ais_irq_req_r & ~$past(ie_r)) == '0) && (ais_irq_req_r == ($past(is_r) & $past(ie_r)));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked alarm interrupt raised");

  property p_latch;
    @(posedge clk) disable iff (rst)
    (ais_change != '0) |=> ((is_r & $past(ais_change)) == $past(ais_change));
  endproperty
  a_latch: assert property (p_latch) else $error("status change not latched");

  property p_rd_clear;
    @(posedge clk) disable iff (rst)
    rd_is && !clear_on_write_select |=> (is_r == $past(ais_change));
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear");

  property p_wr_clear;
    @(posedge clk) disable iff (rst)
    clear_on_write_select && !wr_is |=> ((is_r & $past(is_r)) == $past(is_r));
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("bit cleared without write");

  property p_wr_one_clear;
    @(posedge clk) disable iff (rst)
    clear_on_write_select && wr_is |=> ((is_r & $past(reg_req.wdata) & ~$past(ais_change)) == '0);
  endproperty
  a_wr_one_clear: assert property (p_wr_one_clear) else $error("written bit not cleared");

  property p_bank;
    @(posedge clk) disable iff (rst)
    wr_bank |=> (bank_r == $past(reg_req.wdata)) ##1 (bank_sel_r == bank_decode($past(bank_r)));
  endproperty
  a_bank: assert property (p_bank) else $error("bank pointer not applied");

  property p_bank_sec;
    @(posedge clk) disable iff (rst)
    (bank_r == BANK_CODE_SEC) |=> (bank_sel_r == BANK_SEC);
  endproperty
  a_bank_sec: assert property (p_bank_sec) else $error("secondary bank not selected");

endmodule

// ---- rtl/ltr_pkg.sv ----
// package: register map, field layout, codes and carriers for the template and alarm register slice
package ltr_pkg;

  // ==========================================================
  // sizes
  localparam int NCH = 8;

  // ==========================================================
  // register offsets; OFF_BANK decodes in every bank, the others in the primary bank only
  localparam logic [7:0] OFF_POINTER  = 8'h10;
  localparam logic [7:0] OFF_TEMPLATE = 8'h11;
  localparam logic [7:0] OFF_OUT_DIS  = 8'h12;
  localparam logic [7:0] OFF_AIS      = 8'h13;
  localparam logic [7:0] OFF_AIS_IE   = 8'h14;
  localparam logic [7:0] OFF_AIS_IS   = 8'h15;
  localparam logic [7:0] OFF_BANK     = 8'h1f;

  // ==========================================================
  // bank pointer codes
  localparam logic [7:0] BANK_CODE_PRI  = 8'h00;
  localparam logic [7:0] BANK_CODE_SEC  = 8'haa;
  localparam logic [7:0] BANK_CODE_IND  = 8'h01;
  localparam logic [7:0] BANK_CODE_BERT = 8'h02;

  // ==========================================================
  // template register fields and reset values
  localparam int         TPL_RX_OFF_BIT = 7;
  localparam int         TPL_TX_OFF_BIT = 6;
  localparam int         TPL_IMP_BIT    = 3;
  localparam logic [2:0] TPL_E1         = 3'h0;
  localparam logic [2:0] TPL_RSVD_A     = 3'h1;
  localparam logic [2:0] TPL_RSVD_B     = 3'h2;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [2:0] RST_POINTER    = 3'h0;

  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {BANK_PRI, BANK_SEC, BANK_IND, BANK_BERT, BANK_NONE} ltr_bank_e;
  typedef enum logic [1:0] {OHM_120, OHM_100, OHM_75, OHM_110}             ltr_ohm_e;
  typedef enum logic [1:0] {CRIT_G775, CRIT_ETS, CRIT_T1231}               ltr_crit_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ltr_reg_req_s;

  typedef struct packed {
    logic       rx_match_off;
    logic       tx_term_off;
    logic       t1_mode;
    logic [2:0] cable_tpl;
    ltr_ohm_e   ohm;
    ltr_crit_e  crit;
  } ltr_chan_cfg_s;

  // ==========================================================
  // shared decoders
  function automatic ltr_bank_e bank_decode(input logic [7:0] code);
    return (code == BANK_CODE_PRI)  ? BANK_PRI :
           (code == BANK_CODE_SEC)  ? BANK_SEC :
           (code == BANK_CODE_IND)  ? BANK_IND :
           (code == BANK_CODE_BERT) ? BANK_BERT : BANK_NONE;
  endfunction

  function automatic logic tpl_valid(input logic [2:0] code);
    return (code != TPL_RSVD_A) && (code != TPL_RSVD_B);
  endfunction

endpackage

// ---- rtl/ltr_chan_decode.sv ----
// per-channel decode of a template byte into line mode, impedance and alarm criteria
module ltr_chan_decode
  import ltr_pkg::*;
#(
  parameter bit VARIANT_75 = 1'b0
) (
  // template and criteria
  input  wire logic [7:0]    tpl_byte,
  input  wire logic          crit_bit,
  // decoded channel setup
  output ltr_chan_cfg_s      cfg
);

  // ==========================================================
  // decode
  wire logic       imp_w  = tpl_byte[TPL_IMP_BIT];
  wire logic [2:0] code_w = tpl_byte[2:0];
  wire logic       t1_w   = (code_w != TPL_E1);

  assign cfg.rx_match_off = tpl_byte[TPL_RX_OFF_BIT];
  assign cfg.tx_term_off  = tpl_byte[TPL_TX_OFF_BIT];
  assign cfg.t1_mode      = t1_w;
  assign cfg.cable_tpl    = code_w;
  assign cfg.ohm          = t1_w ? (imp_w ? OHM_110 : OHM_100)
                                 : ((imp_w ^ VARIANT_75) ? OHM_75 : OHM_120);
  assign cfg.crit         = t1_w ? CRIT_T1231 : (crit_bit ? CRIT_ETS : CRIT_G775);

endmodule

// ---- tb/ltr_host_model.sv ----
// host processor model driving the register port
module ltr_host_model
  import ltr_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output ltr_reg_req_s    reg_req,
  input  wire logic [7:0] rd_data_r
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req = '0;

  // ==========================================================
  // bus cycles
  // strobe held to the taking edge, released after it
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    data = rd_data_r;
  endtask
endmodule

// ---- tb/tb_ltr_template_alarm_regs.sv ----
// testbench for the template, output disable, alarm and bank pointer registers
module tb_ltr_template_alarm_regs
  import ltr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  ltr_reg_req_s            reg_req;
  logic [7:0]              rd_data_r;
  logic                    oe_pin = 1'b1;
  logic [NCH-1:0]          ais_detect = 8'h00;
  logic [NCH-1:0]          las_sel = 8'hc0;
  logic                    cow_sel = 1'b0;
  ltr_chan_cfg_s [NCH-1:0] chan_cfg_r;
  logic [NCH-1:0]          tx_hiz_r;
  logic [NCH-1:0]          ais_status_r;
  logic [NCH-1:0]          ais_irq_req_r;
  ltr_bank_e               bank_sel_r;
  int                      num_errors = 0;
  int                      cmp_count = 0;
  logic [7:0]              rdv;

  always #5 clk = ~clk;

  ltr_template_alarm_regs #(.VARIANT_75(1'b0)) DUT (
    .clk(clk), .rst(rst), .reg_req(reg_req), .rd_data_r(rd_data_r), .oe_pin(oe_pin),
    .ais_detect(ais_detect), .loss_alarm_criteria_select(las_sel), .clear_on_write_select(cow_sel),
    .chan_cfg_r(chan_cfg_r), .tx_hiz_r(tx_hiz_r), .ais_status_r(ais_status_r),
    .ais_irq_req_r(ais_irq_req_r), .bank_sel_r(bank_sel_r));

  ltr_host_model host (.clk(clk), .reg_req(reg_req), .rd_data_r(rd_data_r));

  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.read(a, rdv);
    check(16'(rdv), 16'(exp));
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] tpl_of(input int ch);
    logic [2:0] c;
    logic [2:0] code;
    c = 3'(ch);
    code = (c == 3'h7) ? 3'h3 : c + ((c != 3'h0) ? 3'h2 : 3'h0);
    return {c[0], c[1], 2'b00, c[2] ^ c[0], code};
  endfunction

  function automatic ltr_chan_cfg_s exp_cfg(input logic [7:0] d, input logic crit);
    ltr_chan_cfg_s e;
    e.rx_match_off = d[7];
    e.tx_term_off = d[6];
    e.t1_mode = (d[2:0] != 3'h0);
    e.cable_tpl = d[2:0];
    e.ohm = e.t1_mode ? (d[3] ? OHM_110 : OHM_100) : (d[3] ? OHM_75 : OHM_120);
    e.crit = e.t1_mode ? CRIT_T1231 : (crit ? CRIT_ETS : CRIT_G775);
    return e;
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] addrs [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1f};
    for (int i = 0; i < 7; i++) begin
      rdchk(addrs[i], 8'h00);
    end
    check(16'(bank_sel_r), 16'(BANK_PRI));
    check(16'(tx_hiz_r), 16'h0000);
    check(16'(chan_cfg_r[0]), 16'(exp_cfg(8'h00, las_sel[0])));
    $display("test reset done");
  endtask

  task automatic t_template();
    for (int ch = 0; ch < NCH; ch++) begin
      host.write(OFF_POINTER, 8'(ch));
      host.write(OFF_TEMPLATE, tpl_of(ch));
    end
    settle();
    for (int ch = NCH - 1; ch >= 0; ch--) begin
      host.write(OFF_POINTER, 8'(ch));
      rdchk(OFF_POINTER, 8'(ch));
      rdchk(OFF_TEMPLATE, tpl_of(ch));
      check(16'(chan_cfg_r[ch]), 16'(exp_cfg(tpl_of(ch), las_sel[ch])));
    end
    $display("test template done");
  endtask

  task automatic t_reserved();
    logic [7:0] wv [2] = '{8'h89, 8'h42};
    logic [7:0] ev [2] = '{8'h8d, 8'h45};
    host.write(OFF_POINTER, 8'h03);
    for (int i = 0; i < 2; i++) begin
      host.write(OFF_TEMPLATE, wv[i]);
      settle();
      rdchk(OFF_TEMPLATE, ev[i]);
      check(16'(chan_cfg_r[3]), 16'(exp_cfg(ev[i], las_sel[3])));
    end
    $display("test reserved done");
  endtask

  task automatic t_outdis();
    host.write(OFF_OUT_DIS, 8'h5a);
    settle();
    rdchk(OFF_OUT_DIS, 8'h5a);
    check(16'(tx_hiz_r), 16'h005a);
    @(posedge clk);
    oe_pin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(16'(tx_hiz_r), 16'h00ff);
    @(posedge clk);
    oe_pin <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(16'(tx_hiz_r), 16'h005a);
    $display("test output disable done");
  endtask

  task automatic t_alarm();
    host.write(OFF_AIS_IE, 8'h01);
    rdchk(OFF_AIS_IE, 8'h01);
    @(posedge clk);
    ais_detect <= 8'h03;
    settle();
    check(16'(ais_status_r), 16'h0003);
    check(16'(ais_irq_req_r), 16'h0001);
    host.write(OFF_AIS, 8'hff);
    rdchk(OFF_AIS, 8'h03);
    host.write(OFF_AIS_IS, 8'h03);
    rdchk(OFF_AIS_IS, 8'h03);
    rdchk(OFF_AIS_IS, 8'h00);
    check(16'(ais_irq_req_r), 16'h0000);
    @(posedge clk);
    cow_sel <= 1'b1;
    ais_detect <= 8'h01;
    settle();
    check(16'(ais_irq_req_r), 16'h0000);
    rdchk(OFF_AIS_IS, 8'h02);
    rdchk(OFF_AIS_IS, 8'h02);
    host.write(OFF_AIS_IS, 8'h00);
    rdchk(OFF_AIS_IS, 8'h02);
    host.write(OFF_AIS_IS, 8'h02);
    rdchk(OFF_AIS_IS, 8'h00);
    @(posedge clk);
    cow_sel <= 1'b0;
    $display("test alarm done");
  endtask

  task automatic t_bank();
    logic [7:0] codes [5] = '{BANK_CODE_SEC, BANK_CODE_IND, BANK_CODE_BERT, 8'h55, BANK_CODE_PRI};
    ltr_bank_e  expb [5] = '{BANK_SEC, BANK_IND, BANK_BERT, BANK_NONE, BANK_PRI};
    for (int i = 0; i < 5; i++) begin
      host.write(OFF_BANK, codes[i]);
      host.write(OFF_OUT_DIS, 8'hff);
      settle();
      check(16'(bank_sel_r), 16'(expb[i]));
      rdchk(OFF_BANK, codes[i]);
      rdchk(OFF_OUT_DIS, (i == 4) ? 8'hff : 8'h00);
      check(16'(tx_hiz_r), (i == 4) ? 16'h00ff : 16'h005a);
    end
    rdchk(8'h20, 8'h00);
    $display("test bank done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_template();
    t_reserved();
    t_outdis();
    t_alarm();
    t_bank();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
